/* File: core/trigger_map.vh */
`ifndef TRIGGER_MAP_VH
`define TRIGGER_MAP_VH

// ****************************************************************
// Register map (register indices, and byte addresses on the APB side)
// ****************************************************************
`define IDX_INSN_COUNT   16'h07A1
`define IDX_COMPARE      16'h07A2
`define ADDR_INSN_COUNT  16'h1E84
`define ADDR_STATUS      16'h0100
`define MATCH_STRIDE_LG  3

// ****************************************************************
// Match control fields
// ****************************************************************
`define MC_TYPE_HI       31
`define MC_TYPE_LO       28
`define MC_TYPE_VAL      4'h2
`define MC_DMODE         27
`define MC_SELECT        19
`define MC_TIMING        18
`define MC_ACT_HI        17
`define MC_ACT_LO        12
`define MC_CHAIN         11
`define MC_MATCH_HI      10
`define MC_MATCH_LO      7
`define MC_U             3
`define MC_EXECUTE       2
`define MC_STORE         1
`define MC_LOAD          0
`define MC_RESET         32'h20000000

// ****************************************************************
// Instruction count fields
// ****************************************************************
`define IC_TYPE_VAL      4'h3
`define IC_DMODE         27
`define IC_CNT_HI        23
`define IC_CNT_LO        10
`define IC_U             6
`define IC_ACT_HI        5
`define IC_ACT_LO        0
`define IC_CNT_RESET     14'h0001
`define IC_RESET         32'h30000400

// ****************************************************************
// Action and match codes
// ****************************************************************
`define ACT_EXCEPTION    6'h00
`define ACT_HALT         6'h01
`define ACT_TRACE_ON     6'h02
`define ACT_TRACE_OFF    6'h03
`define ACT_TRACE_EMIT   6'h04
`define MATCH_LAST       4'h5

// ****************************************************************
// Status fields
// ****************************************************************
`define ST_TRACE_ON      0
`define ST_HIT_LO        8
`define ST_IC_HIT        16

`endif

/* File: core/trigger_match_and_insn_count.v */
`timescale 1ns/1ns
`include "trigger_map.vh"

module trigger_match_and_insn_count #(
   parameter NUM_MATCH = 2
)(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [15:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        debug_mode,
   input  wire [1:0]  priv_level,
   input  wire        retire_valid,
   input  wire [31:0] retire_pc,
   input  wire [31:0] retire_insn,
   input  wire        mem_valid,
   input  wire        mem_store,
   input  wire [31:0] mem_addr,
   input  wire [31:0] mem_data,
   output reg         debug_exception_q,
   output reg         halt_req_q,
   output reg         trace_on_q,
   output reg         trace_emit_q,
   output reg  [31:0] trace_data_q
);

   // ****************************************************************
   // Match function
   // ****************************************************************
   function cmp_fn;
      input [3:0]  mode;
      input [31:0] v;
      input [31:0] t;
      reg   [31:0] mask;
      begin
         mask = ~(t ^ (t + 32'h00000001));
         case (mode)
            4'h0: cmp_fn = (v == t);
            4'h1: cmp_fn = (((v ^ t) & mask) == 32'h00000000);
            4'h2: cmp_fn = (v >= t);
            4'h3: cmp_fn = (v < t);
            4'h4: cmp_fn = ((v[15:0] & t[31:16]) == t[15:0]);
            4'h5: cmp_fn = ((v[31:16] & t[31:16]) == t[15:0]);
            default: cmp_fn = 1'b0;
         endcase
      end
   endfunction

   // ****************************************************************
   // Write legalisation
   // ****************************************************************
   function [31:0] legal_mc;
      input [31:0] w;
      input [31:0] old;
      input        dbg;
      reg          dm;
      begin
         legal_mc = 32'h00000000;
         dm = dbg ? w[`MC_DMODE] : old[`MC_DMODE];
         legal_mc[`MC_TYPE_HI:`MC_TYPE_LO] = `MC_TYPE_VAL;
         legal_mc[`MC_DMODE] = dm;
         legal_mc[`MC_SELECT] = w[`MC_SELECT];
         if (w[`MC_ACT_HI:`MC_ACT_LO] <= `ACT_TRACE_EMIT &&
             (w[`MC_ACT_HI:`MC_ACT_LO] != `ACT_HALT || dm)) begin
            legal_mc[`MC_ACT_HI:`MC_ACT_LO] = w[`MC_ACT_HI:`MC_ACT_LO];
         end
         legal_mc[`MC_CHAIN] = w[`MC_CHAIN];
         if (w[`MC_MATCH_HI:`MC_MATCH_LO] <= `MATCH_LAST) begin
            legal_mc[`MC_MATCH_HI:`MC_MATCH_LO] = w[`MC_MATCH_HI:`MC_MATCH_LO];
         end
         legal_mc[6:0] = w[6:0];
      end
   endfunction

   function [31:0] legal_ic;
      input [31:0] w;
      input [31:0] old;
      input        dbg;
      reg          dm;
      begin
         legal_ic = 32'h00000000;
         dm = dbg ? w[`IC_DMODE] : old[`IC_DMODE];
         legal_ic[`MC_TYPE_HI:`MC_TYPE_LO] = `IC_TYPE_VAL;
         legal_ic[`IC_DMODE] = dm;
         legal_ic[`IC_CNT_HI:`IC_CNT_LO] = w[`IC_CNT_HI:`IC_CNT_LO];
         legal_ic[9:6] = w[9:6];
         if (w[`IC_ACT_HI:`IC_ACT_LO] <= `ACT_TRACE_EMIT &&
             (w[`IC_ACT_HI:`IC_ACT_LO] != `ACT_HALT || dm)) begin
            legal_ic[`IC_ACT_HI:`IC_ACT_LO] = w[`IC_ACT_HI:`IC_ACT_LO];
         end
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   reg  [31:0]          mctl_q [0:NUM_MATCH-1];
   reg  [31:0]          mcmp_q [0:NUM_MATCH-1];
   reg  [31:0]          ictl_q;
   reg  [NUM_MATCH-1:0] hit_q;
   reg                  ic_hit_q;
   wire [NUM_MATCH-1:0] raw;
   wire [NUM_MATCH-1:0] eff;
   wire [NUM_MATCH-1:0] fire;
   wire [31:0]          tval [0:NUM_MATCH-1];
   wire                 apb_wr;
   wire                 apb_setup_done;
   reg  [31:0]          rd_d;
   reg                  hit_d;
   integer              k;
   integer              k_act;
   integer              k_rd;

   assign apb_wr         = psel & penable & pready & pwrite;
   assign apb_setup_done = psel & penable & ~pready;

   // ****************************************************************
   // Match triggers
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_MATCH; g = g + 1) begin : gen_match
         wire [31:0] c;
         wire [31:0] ex_v;
         wire [31:0] mem_v;
         wire        lvl_en;
         wire        ex_m;
         wire        ld_m;
         wire        st_m;
         assign c      = mctl_q[g];
         assign lvl_en = c[`MC_U + priv_level];
         assign ex_v   = c[`MC_SELECT] ? retire_insn : retire_pc;
         assign mem_v  = c[`MC_SELECT] ? mem_data : mem_addr;
         assign ex_m   = retire_valid & c[`MC_EXECUTE] &
                         cmp_fn(c[`MC_MATCH_HI:`MC_MATCH_LO], ex_v, mcmp_q[g]);
         assign st_m   = mem_valid & mem_store & c[`MC_STORE] &
                         cmp_fn(c[`MC_MATCH_HI:`MC_MATCH_LO], mem_v, mcmp_q[g]);
         assign ld_m   = mem_valid & ~mem_store & c[`MC_LOAD] &
                         cmp_fn(c[`MC_MATCH_HI:`MC_MATCH_LO], mem_v, mcmp_q[g]);
         assign raw[g] = lvl_en & (ex_m | st_m | ld_m);
         if (g == 0) begin : gen_first
            assign eff[g] = raw[g];
         end else begin : gen_chained
            assign eff[g] = raw[g] & ~(mctl_q[g-1][`MC_CHAIN] & ~eff[g-1]);
         end
         assign fire[g] = eff[g] & ~c[`MC_CHAIN];
         assign tval[g] = ex_m ? retire_pc : mem_v;
      end
   endgenerate

   // ****************************************************************
   // Instruction count trigger
   // ****************************************************************
   // The count stops at zero; the level enables are left as software wrote them.
   wire [13:0] ic_cnt;
   wire        ic_dec;
   wire        ic_fire;
   assign ic_cnt  = ictl_q[`IC_CNT_HI:`IC_CNT_LO];
   assign ic_dec  = retire_valid & ictl_q[`IC_U + priv_level] & (ic_cnt != 14'h0000);
   assign ic_fire = ic_dec & (ic_cnt == 14'h0001);

   // ****************************************************************
   // Action dispatch
   // ****************************************************************
   reg        exc_d;
   reg        halt_d;
   reg        ton_d;
   reg        toff_d;
   reg        emit_d;
   reg [31:0] tdata_d;
   reg [5:0]  act;

   // The lowest-index emit wins, and the count trigger yields to every match.
   always @* begin
      exc_d   = 1'b0;
      halt_d  = 1'b0;
      ton_d   = 1'b0;
      toff_d  = 1'b0;
      emit_d  = 1'b0;
      tdata_d = trace_data_q;
      act     = ictl_q[`IC_ACT_HI:`IC_ACT_LO];
      if (ic_fire) begin
         exc_d  = (act == `ACT_EXCEPTION);
         halt_d = (act == `ACT_HALT);
         ton_d  = (act == `ACT_TRACE_ON);
         toff_d = (act == `ACT_TRACE_OFF);
         if (act == `ACT_TRACE_EMIT) begin
            emit_d  = 1'b1;
            tdata_d = retire_pc;
         end
      end
      for (k_act = NUM_MATCH - 1; k_act >= 0; k_act = k_act - 1) begin
         act = mctl_q[k_act][`MC_ACT_HI:`MC_ACT_LO];
         if (fire[k_act]) begin
            exc_d  = exc_d | (act == `ACT_EXCEPTION);
            halt_d = halt_d | (act == `ACT_HALT);
            ton_d  = ton_d | (act == `ACT_TRACE_ON);
            toff_d = toff_d | (act == `ACT_TRACE_OFF);
            if (act == `ACT_TRACE_EMIT) begin
               emit_d  = 1'b1;
               tdata_d = tval[k_act];
            end
         end
      end
   end

   // Stop wins when start and stop arrive together.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         debug_exception_q <= 1'b0;
         halt_req_q        <= 1'b0;
         trace_on_q        <= 1'b0;
         trace_emit_q      <= 1'b0;
         trace_data_q      <= 32'h00000000;
      end else begin
         debug_exception_q <= exc_d;
         halt_req_q        <= halt_d;
         trace_emit_q      <= emit_d;
         trace_data_q      <= tdata_d;
         if (toff_d) begin
            trace_on_q <= 1'b0;
         end else if (ton_d) begin
            trace_on_q <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Register read decode
   // ****************************************************************
   // Offsets that decode to nothing read as zero and answer with an error.
   always @* begin
      rd_d  = 32'h00000000;
      hit_d = 1'b0;
      if (paddr == `ADDR_INSN_COUNT) begin
         rd_d  = ictl_q;
         hit_d = 1'b1;
      end
      if (paddr == `ADDR_STATUS) begin
         rd_d[`ST_TRACE_ON]                     = trace_on_q;
         rd_d[`ST_HIT_LO +: NUM_MATCH]          = hit_q;
         rd_d[`ST_IC_HIT]                       = ic_hit_q;
         hit_d                                  = 1'b1;
      end
      for (k_rd = 0; k_rd < NUM_MATCH; k_rd = k_rd + 1) begin
         if (paddr[15:`MATCH_STRIDE_LG] == k_rd[12:0] && paddr[1:0] == 2'b00) begin
            rd_d  = paddr[2] ? mcmp_q[k_rd] : mctl_q[k_rd];
            hit_d = 1'b1;
         end
      end
   end

   // ****************************************************************
   // APB slave, one wait state
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (apb_setup_done) begin
         pready  <= 1'b1;
         pslverr <= ~hit_d;
         prdata  <= pwrite ? 32'h00000000 : rd_d;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ****************************************************************
   // Register writes and trigger state
   // ****************************************************************
   // Registers whose dmode is set only accept writes from debug mode.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ictl_q   <= `IC_RESET;
         hit_q    <= {NUM_MATCH{1'b0}};
         ic_hit_q <= 1'b0;
         for (k = 0; k < NUM_MATCH; k = k + 1) begin
            mctl_q[k] <= `MC_RESET;
            mcmp_q[k] <= 32'h00000000;
         end
      end else begin
         if (apb_wr && paddr == `ADDR_INSN_COUNT && hit_d &&
             (debug_mode || !ictl_q[`IC_DMODE])) begin
            ictl_q <= legal_ic(pwdata, ictl_q, debug_mode);
         end else if (ic_dec) begin
            ictl_q[`IC_CNT_HI:`IC_CNT_LO] <= ic_cnt - 14'h0001;
         end
         for (k = 0; k < NUM_MATCH; k = k + 1) begin
            if (apb_wr && paddr[15:`MATCH_STRIDE_LG] == k[12:0] && paddr[1:0] == 2'b00 &&
                (debug_mode || !mctl_q[k][`MC_DMODE])) begin
               if (paddr[2]) begin
                  mcmp_q[k] <= pwdata;
               end else begin
                  mctl_q[k] <= legal_mc(pwdata, mctl_q[k], debug_mode);
               end
            end
         end
         // Sticky hit flags: a new hit wins over a write-one clear.
         if (apb_wr && paddr == `ADDR_STATUS) begin
            hit_q    <= (hit_q & ~pwdata[`ST_HIT_LO +: NUM_MATCH]) | fire;
            ic_hit_q <= (ic_hit_q & ~pwdata[`ST_IC_HIT]) | ic_fire;
         end else begin
            hit_q    <= hit_q | fire;
            ic_hit_q <= ic_hit_q | ic_fire;
         end
      end
   end

endmodule // trigger_match_and_insn_count

/* File: bench/trigger_match_and_insn_count_props.sv */
`timescale 1ns/1ns
module trigger_props #(
   parameter NUM_MATCH = 2
)(
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   input wire        retire_valid,
   input wire        mem_valid,
   input wire        debug_exception_q,
   input wire        halt_req_q,
   input wire        trace_on_q,
   input wire        trace_emit_q,
   input wire [31:0] trace_data_q
);
   // ****************************************
   // Action and bus timing checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire core_ev = retire_valid | mem_valid;
   property p_exc; debug_exception_q |-> $past(core_ev); endproperty
   a_exc: assert property (p_exc) else $error("exception without core event");
   property p_halt; halt_req_q |-> $past(core_ev); endproperty
   a_halt: assert property (p_halt) else $error("halt without core event");
   property p_emit; trace_emit_q |-> $past(core_ev); endproperty
   a_emit: assert property (p_emit) else $error("emit without core event");
   property p_trace; $changed(trace_on_q) |-> $past(core_ev); endproperty
   a_trace: assert property (p_trace) else $error("trace state moved alone");
   property p_hold; !trace_emit_q |-> $stable(trace_data_q); endproperty
   a_hold: assert property (p_hold) else $error("trace data moved without emit");
   property p_quiet; !core_ev |=> !(debug_exception_q | halt_req_q | trace_emit_q); endproperty
   a_quiet: assert property (p_quiet) else $error("action without match");
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("ready not after one wait state");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_err; pslverr |-> pready && psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside completion");
endmodule // trigger_props
bind trigger_match_and_insn_count trigger_props #(.NUM_MATCH(NUM_MATCH)) u_props (.pclk, .presetn,
   .psel, .penable, .pready, .pslverr, .retire_valid, .mem_valid, .debug_exception_q, .halt_req_q,
   .trace_on_q, .trace_emit_q, .trace_data_q);

/* File: bench/core_model.sv */
`timescale 1ns/1ns
module core_model (
   input  wire         pclk,
   output logic [1:0]  priv_level,
   output logic        retire_valid,
   output logic [31:0] retire_pc,
   output logic [31:0] retire_insn,
   output logic        mem_valid,
   output logic        mem_store,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_data
);
   // ****************************************
   // Pipeline events, one cycle each
   // ****************************************
   initial begin
      {priv_level, retire_valid, retire_pc, retire_insn} = '0;
      {mem_valid, mem_store, mem_addr, mem_data} = '0;
   end
   // Idle pc, insn, address and data values flip so that stale values never look valid.
   task retire(input [1:0] pl, input [31:0] pc, input [31:0] insn);
      @(posedge pclk);
      priv_level <= pl;
      retire_valid <= 1'b1;
      retire_pc <= pc;
      retire_insn <= insn;
      @(posedge pclk);
      retire_valid <= 1'b0;
      retire_pc <= ~pc;
      retire_insn <= ~insn;
   endtask
   task access(input st, input [31:0] a, input [31:0] d);
      @(posedge pclk);
      priv_level <= 2'h3;
      mem_valid <= 1'b1;
      mem_store <= st;
      mem_addr <= a;
      mem_data <= d;
      @(posedge pclk);
      mem_valid <= 1'b0;
      mem_addr <= ~a;
      mem_data <= ~d;
   endtask
endmodule // core_model

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`include "trigger_map.vh"
module testbench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, debug_mode = 0, err;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   wire  [31:0] prdata, retire_pc, retire_insn, mem_addr, mem_data, trace_data_q;
   wire  [1:0]  priv_level;
   wire         pready, pslverr, retire_valid, mem_valid, mem_store;
   wire         debug_exception_q, halt_req_q, trace_on_q, trace_emit_q;
   int          n_fail = 0, checked = 0;
   logic [31:0] tcmp[6] = '{32'h1000, 32'h100F, 32'h2000, 32'h2000, 32'h00FF0012, 32'h00FF0034};
   logic [31:0] thit[6] = '{32'h1000, 32'h101F, 32'h2000, 32'h1FFF, 32'hABCDFF12, 32'h12340000};
   logic [31:0] tmis[6] = '{32'h1004, 32'h1020, 32'h1FFF, 32'h2000, 32'h00000013, 32'h12350000};
   always #4 pclk = ~pclk;
   trigger_match_and_insn_count dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .debug_mode, .priv_level, .retire_valid, .retire_pc, .retire_insn,
      .mem_valid, .mem_store, .mem_addr, .mem_data, .debug_exception_q, .halt_req_q, .trace_on_q,
      .trace_emit_q, .trace_data_q);
   core_model core (.pclk, .priv_level, .retire_valid, .retire_pc, .retire_insn, .mem_valid,
      .mem_store, .mem_addr, .mem_data);
   // ****************************************
   // Bus, event and compare tasks
   // ****************************************
   task chk(input string nm, input [31:0] e, input [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input w, input [15:0] a, input [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk("pready", 1, pready);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task rdchk(input string nm, input [15:0] a, input [31:0] e);
      apb(0, a, 0);
      chk(nm, e, rd);
   endtask
   task hit(input string nm, input [1:0] pl, input [31:0] pc, input [31:0] insn, input e);
      core.retire(pl, pc, insn);
      #1 chk(nm, e, debug_exception_q);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      rdchk("ctrl0", 16'h0000, `MC_RESET);
      rdchk("cmp0", 16'h0004, 0);
      rdchk("insn_count", `ADDR_INSN_COUNT, `IC_RESET);
      rdchk("status0", `ADDR_STATUS, 0);
      apb(0, 16'h0200, 0);
      chk("unmapped", 1, err);
   endtask
   task t_modes;
      for (int i = 0; i < 6; i++) begin
         apb(1, 0, 32'h20000044 | (i << 7));
         apb(1, 4, tcmp[i]);
         hit("mode_hit", 3, thit[i], 0, 1);
         hit("mode_miss", 3, tmis[i], 0, 0);
      end
      apb(1, 0, 32'h20005344);
      rdchk("reserved", 0, 32'h20000044);
   endtask
   task t_priv;
      apb(1, 4, 32'h1000);
      apb(1, 0, 32'h2000000C);
      hit("priv_m", 3, 32'h1000, 0, 0);
      hit("priv_u", 0, 32'h1000, 0, 1);
      apb(1, 0, 32'h20000042);
      hit("no_exec", 3, 32'h1000, 0, 0);
      core.access(0, 32'h1000, 0);
      #1 chk("load_off", 0, debug_exception_q);
      core.access(1, 32'h1000, 0);
      #1 chk("store_on", 1, debug_exception_q);
      apb(1, 0, 32'h20000041);
      core.access(0, 32'h1000, 0);
      #1 chk("load_on", 1, debug_exception_q);
   endtask
   task t_actions;
      apb(1, 0, 32'h20001044);
      rdchk("halt_nodm", 0, 32'h20000044);
      apb(1, 0, 32'h20002044);
      hit("trace_exc", 3, 32'h1000, 0, 0);
      chk("trace_on", 1, trace_on_q);
      apb(1, 0, 32'h20003044);
      core.retire(3, 32'h1000, 0);
      #1 chk("trace_off", 0, trace_on_q);
      apb(1, 0, 32'h20004044);
      core.retire(3, 32'h1000, 0);
      #1 chk("emit", 1, trace_emit_q);
      chk("emit_pc", 32'h1000, trace_data_q);
      apb(1, 0, 32'h20004142);
      core.access(1, 32'h1234, 32'hDEAD);
      #1 chk("emit_st", 1, trace_emit_q);
      chk("emit_addr", 32'h1234, trace_data_q);
      @(posedge pclk) debug_mode <= 1'b1;
      apb(1, 0, 32'h28001044);
      core.retire(3, 32'h1000, 0);
      #1 chk("halt", 1, halt_req_q);
      @(posedge pclk) debug_mode <= 1'b0;
      apb(1, 0, 32'h20000044);
      rdchk("dmode_lock", 0, 32'h28001044);
      @(posedge pclk) debug_mode <= 1'b1;
      apb(1, 0, 32'h20000044);
      @(posedge pclk) debug_mode <= 1'b0;
      hit("exc", 3, 32'h1000, 0, 1);
   endtask
   task t_chain;
      apb(1, 0, 32'h20000844);
      apb(1, 16'h0008, 32'h20080044);
      apb(1, 16'h000C, 32'hBEEF);
      hit("chain_pass", 3, 32'h1000, 32'hBEEF, 1);
      hit("chain_block", 3, 32'h2000, 32'hBEEF, 0);
      hit("chain_quiet", 3, 32'h1000, 0, 0);
      apb(1, 0, 32'h20000044);
      hit("own0", 3, 32'h1000, 0, 1);
      hit("own1", 3, 32'h2000, 32'hBEEF, 1);
   endtask
   task t_insn_count;
      apb(1, 0, `MC_RESET);
      apb(1, 16'h0008, `MC_RESET);
      apb(1, `ADDR_INSN_COUNT, 32'h30000A00);
      rdchk("ic_two", `ADDR_INSN_COUNT, 32'h30000A00);
      hit("ic_user", 0, 32'h3000, 0, 0);
      hit("ic_one", 3, 32'h3000, 0, 0);
      hit("ic_fire", 3, 32'h3000, 0, 1);
      rdchk("ic_zero", `ADDR_INSN_COUNT, 32'h30000200);
      hit("ic_stay", 3, 32'h3000, 0, 0);
      rdchk("status", `ADDR_STATUS, 32'h00010300);
      apb(1, `ADDR_STATUS, 32'h00010300);
      rdchk("status_clr", `ADDR_STATUS, 0);
   endtask
   task give_verdict;
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_modes;
      t_priv;
      t_actions;
      t_chain;
      t_insn_count;
      give_verdict;
   end
   initial begin
      #200000;
      n_fail++;
      give_verdict;
   end
endmodule // testbench
